// ### logic/gfip_pkg.sv
// package: register map, field layout and reset values of the gpio input/protect block
package gfip_pkg;
  // ****************************************
  // widths
  // ****************************************
  localparam int unsigned LINES = 32;
  localparam int unsigned ADDR_W = 8;
  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] OFF_LINE_CTRL_TAKE = 8'h00;
  localparam logic [7:0] OFF_LINE_CTRL_RELEASE = 8'h04;
  localparam logic [7:0] OFF_LINE_CTRL_STATUS = 8'h08;
  localparam logic [7:0] OFF_DRIVE_ENABLE_SET = 8'h10;
  localparam logic [7:0] OFF_DRIVE_ENABLE_CLEAR = 8'h14;
  localparam logic [7:0] OFF_DRIVE_ENABLE_STATUS = 8'h18;
  localparam logic [7:0] OFF_FILTER_ENABLE_SET = 8'h20;
  localparam logic [7:0] OFF_FILTER_ENABLE_CLEAR = 8'h24;
  localparam logic [7:0] OFF_FILTER_STATUS = 8'h28;
  localparam logic [7:0] OFF_OUT_LEVEL_SET = 8'h30;
  localparam logic [7:0] OFF_OUT_LEVEL_CLEAR = 8'h34;
  localparam logic [7:0] OFF_OUT_LEVEL_STATUS = 8'h38;
  localparam logic [7:0] OFF_PIN_LEVEL_READBACK = 8'h3C;
  localparam logic [7:0] OFF_CHANGE_IRQ_ENABLE = 8'h40;
  localparam logic [7:0] OFF_CHANGE_IRQ_DISABLE = 8'h44;
  localparam logic [7:0] OFF_CHANGE_IRQ_MASK = 8'h48;
  localparam logic [7:0] OFF_CHANGE_IRQ_STATUS = 8'h4C;
  localparam logic [7:0] OFF_OPEN_DRAIN_SET = 8'h50;
  localparam logic [7:0] OFF_OPEN_DRAIN_CLEAR = 8'h54;
  localparam logic [7:0] OFF_OPEN_DRAIN_STATUS = 8'h58;
  localparam logic [7:0] OFF_PULLUP_OFF = 8'h60;
  localparam logic [7:0] OFF_PULLUP_ON = 8'h64;
  localparam logic [7:0] OFF_PULLUP_STATUS = 8'h68;
  localparam logic [7:0] OFF_PERIPH_FIRST_SELECT = 8'h70;
  localparam logic [7:0] OFF_PERIPH_SECOND_SELECT = 8'h74;
  localparam logic [7:0] OFF_PERIPH_SELECT_STATUS = 8'h78;
  localparam logic [7:0] OFF_DIRECT_WRITE_MASK_SET = 8'hA0;
  localparam logic [7:0] OFF_DIRECT_WRITE_MASK_CLEAR = 8'hA4;
  localparam logic [7:0] OFF_DIRECT_WRITE_MASK_STATUS = 8'hA8;
  localparam logic [7:0] OFF_PAD_DELAY_CODES0 = 8'hC0;
  localparam logic [7:0] OFF_PAD_DELAY_CODES3 = 8'hCC;
  localparam logic [7:0] OFF_WRITE_PROTECT_MODE = 8'hE4;
  localparam logic [7:0] OFF_WRITE_PROTECT_STATUS = 8'hE8;
  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int unsigned PROTECT_ENABLE_BIT = 0;
  localparam int unsigned VIOLATION_FLAG_BIT = 0;
  localparam int unsigned VIOLATION_SOURCE_LSB = 8;
  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
  localparam logic [31:0] RESET_LINE_CTRL = 32'hFFFF_FFFF;
  localparam int unsigned DELAY_CODE_W = 4;
  localparam int unsigned DELAY_REGS = 4;
  // pads with a working delay: port-a lines 30..23 and 9..2 (port-c set via parameter)
  localparam logic [31:0] DELAY_PADS_PORT_A = 32'h7F80_03FC;
  localparam logic [31:0] DELAY_PADS_PORT_C = 32'h0000_10FC;
  // ahb transfer types
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
endpackage

// ### logic/gfip_glitch_filter.sv
// glitch filter for one group of input lines, working on both clock edges
`timescale 1ns/1ps
`default_nettype none
module gfip_glitch_filter #(
  parameter int unsigned WIDTH = 32
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] pinSync,
  input wire logic [WIDTH-1:0] filterOn,
  output logic [WIDTH-1:0] filtered
);
  // ****************************************
  // half-cycle sampling
  // ****************************************
  logic [WIDTH-1:0] fallSample_q;
  logic [WIDTH-1:0] fallSample_d;
  logic [WIDTH-1:0] held_q;
  logic [WIDTH-1:0] held_d;

  initial begin
    if (WIDTH < 1) $error("gfip_glitch_filter: WIDTH must be at least 1");
  end

  // a level seen on the falling edge and again on the rising edge lasted
  // a half period at least; shorter pulses never show in both samples
  always_comb begin
    fallSample_d = pinSync;
  end

  always_ff @(negedge clk or posedge reset) begin
    if (reset) begin
      fallSample_q <= '0;
    end else begin
      fallSample_q <= fallSample_d;
    end
  end

  // per filtered line: accept a new level only when both half-period samples agree
  always_comb begin
    held_d = held_q;
    for (int i = 0; i < WIDTH; i++) begin
      if (!filterOn[i] || (pinSync[i] == fallSample_q[i])) begin
        held_d[i] = pinSync[i];
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      held_q <= '0;
    end else begin
      held_q <= held_d;
    end
  end

  // unfiltered lines bypass the hold register so they carry no extra cycle
  assign filtered = (filterOn & held_q) | (~filterOn & pinSync);
endmodule
`default_nettype wire

// ### logic/gfip_gpio_filter_irq_protect.sv
// top: gpio input filter, change interrupt, write protection and delay codes
//
// The register offsets and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module gfip_gpio_filter_irq_protect #(
  parameter int unsigned LINES = gfip_pkg::LINES,
  parameter logic [31:0] DELAY_PADS = gfip_pkg::DELAY_PADS_PORT_A
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [LINES-1:0] pinIn,
  output logic [LINES-1:0] periphIn,
  output logic changeIrq,
  output logic [LINES-1:0] lineCtrl,
  output logic [LINES-1:0] driveEnable,
  output logic [LINES-1:0] outLevel,
  output logic [LINES-1:0] openDrain,
  output logic [LINES-1:0] pullupOff,
  output logic [LINES-1:0] periphSecond,
  output logic [4*LINES-1:0] padDelayCodes
);
  // ****************************************
  // parameter checks
  // ****************************************
  initial begin
    if (LINES < 1 || LINES > 32) $error("gfip: LINES must be 1 to 32");
  end
  // ****************************************
  // input synchronisers
  // ****************************************
  logic [LINES-1:0] sync1_q; // first stage, read only by sync2
  logic [LINES-1:0] sync2_q;
  logic [LINES-1:0] sync3_q;
  logic [LINES-1:0] pinStable_q; // level once stages two and three agree
  logic [LINES-1:0] pinStable_d;
  // a pin change is counted once the second and third stages agree
  always_comb begin
    pinStable_d = pinStable_q;
    for (int i = 0; i < LINES; i++) begin
      if (sync2_q[i] == sync3_q[i]) begin
        pinStable_d[i] = sync3_q[i];
      end
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      pinStable_q <= '0;
    end else begin
      sync1_q <= pinIn;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pinStable_q <= pinStable_d;
    end
  end

  // peripherals see the synchronised pin with no filter in the way
  assign periphIn = pinStable_q;
  // ****************************************
  // glitch filter
  // ****************************************
  logic [LINES-1:0] filterStatus_q; // filter_status
  logic [LINES-1:0] filtered;
  // the filter runs off clk only, so a gated clock stops it entirely
  gfip_glitch_filter #(
    .WIDTH(LINES)
  ) uFilter (
    .clk(clk),
    .reset(reset),
    .pinSync(pinStable_q),
    .filterOn(filterStatus_q),
    .filtered(filtered)
  );
  // ****************************************
  // bus address phase capture
  // ****************************************
  logic phaseValid_q;
  logic phaseValid_d;
  logic phaseWrite_q;
  logic phaseWrite_d;
  logic [7:0] phaseAddr_q;
  logic [7:0] phaseAddr_d;
  logic busRead; // read accepted in the address phase

  // every transfer finishes in one data-phase cycle, so hreadyout stays high
  always_comb begin
    phaseValid_d = hsel && hready && (htrans == gfip_pkg::HTRANS_NONSEQ
                   || htrans == gfip_pkg::HTRANS_SEQ);
    phaseWrite_d = hwrite;
    phaseAddr_d = haddr[7:0];
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phaseValid_q <= 1'b0;
      phaseWrite_q <= 1'b0;
      phaseAddr_q <= 8'h00;
    end else begin
      phaseValid_q <= phaseValid_d;
      phaseWrite_q <= phaseWrite_d;
      phaseAddr_q <= phaseAddr_d;
    end
  end

  assign busRead = phaseValid_d && !hwrite;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ****************************************
  // register state
  // ****************************************
  logic wrStrobe;
  logic protectOn;
  logic protectedTarget;
  logic writeAllowed;
  logic [31:0] wdat;
  logic [LINES-1:0] irqMask_q, irqMask_d;
  logic [LINES-1:0] irqStatus_q, irqStatus_d;
  logic [LINES-1:0] filterStatus_d;
  logic [LINES-1:0] lineCtrl_q, lineCtrl_d;
  logic [LINES-1:0] drive_q, drive_d;
  logic [LINES-1:0] level_q, level_d;
  logic [LINES-1:0] drain_q, drain_d;
  logic [LINES-1:0] pullOff_q, pullOff_d;
  logic [LINES-1:0] second_q, second_d;
  logic [LINES-1:0] directMask_q, directMask_d;
  logic [31:0] delay_q [gfip_pkg::DELAY_REGS];
  logic [31:0] delay_d [gfip_pkg::DELAY_REGS];
  logic protectMode_q, protectMode_d; // protect_enable_bit
  logic violation_q, violation_d; // violation_flag
  logic [7:0] violationSrc_q, violationSrc_d; // violation_source
  logic [LINES-1:0] lastSample_q; // previous filtered sample
  logic [LINES-1:0] changed;
  logic statusRead;
  logic protectStatusRead;

  assign wrStrobe = phaseValid_q && phaseWrite_q;
  assign wdat = hwdata;
  assign protectOn = protectMode_q;

  // the sixteen set/clear registers covered by write protection
  always_comb begin
    case (phaseAddr_q)
      gfip_pkg::OFF_LINE_CTRL_TAKE, gfip_pkg::OFF_LINE_CTRL_RELEASE,
      gfip_pkg::OFF_DRIVE_ENABLE_SET, gfip_pkg::OFF_DRIVE_ENABLE_CLEAR,
      gfip_pkg::OFF_FILTER_ENABLE_SET, gfip_pkg::OFF_FILTER_ENABLE_CLEAR,
      gfip_pkg::OFF_OUT_LEVEL_SET, gfip_pkg::OFF_OUT_LEVEL_CLEAR,
      gfip_pkg::OFF_OPEN_DRAIN_SET, gfip_pkg::OFF_OPEN_DRAIN_CLEAR,
      gfip_pkg::OFF_PULLUP_OFF, gfip_pkg::OFF_PULLUP_ON,
      gfip_pkg::OFF_PERIPH_FIRST_SELECT, gfip_pkg::OFF_PERIPH_SECOND_SELECT,
      gfip_pkg::OFF_DIRECT_WRITE_MASK_SET,
      gfip_pkg::OFF_DIRECT_WRITE_MASK_CLEAR: protectedTarget = 1'b1;
      default: protectedTarget = 1'b0;
    endcase
  end

  assign writeAllowed = wrStrobe && !(protectOn && protectedTarget);

  // change detection compares two successive filtered samples on every line,
  // whatever its direction or owner
  assign changed = filtered ^ lastSample_q;

  // read clears act in the address phase; data phase returns the old value
  assign statusRead = busRead && haddr[7:0] == gfip_pkg::OFF_CHANGE_IRQ_STATUS;
  assign protectStatusRead = busRead
                             && haddr[7:0] == gfip_pkg::OFF_WRITE_PROTECT_STATUS;

  // next state of all software-visible registers
  always_comb begin
    filterStatus_d = filterStatus_q;
    irqMask_d = irqMask_q;
    lineCtrl_d = lineCtrl_q;
    drive_d = drive_q;
    level_d = level_q;
    drain_d = drain_q;
    pullOff_d = pullOff_q;
    second_d = second_q;
    directMask_d = directMask_q;
    delay_d = delay_q;
    protectMode_d = protectMode_q;
    violation_d = violation_q;
    violationSrc_d = violationSrc_q;
    // clear on read first, so a change in the same cycle still lands
    irqStatus_d = statusRead ? '0 : irqStatus_q;
    irqStatus_d = irqStatus_d | changed;
    if (protectStatusRead) begin
      violation_d = 1'b0;
    end
    if (wrStrobe && protectOn && protectedTarget) begin
      violation_d = 1'b1;
      violationSrc_d = phaseAddr_q;
    end
    if (writeAllowed) begin
      case (phaseAddr_q)
        gfip_pkg::OFF_LINE_CTRL_TAKE: lineCtrl_d = lineCtrl_q | wdat[LINES-1:0];
        gfip_pkg::OFF_LINE_CTRL_RELEASE: lineCtrl_d = lineCtrl_q & ~wdat[LINES-1:0];
        gfip_pkg::OFF_DRIVE_ENABLE_SET: drive_d = drive_q | wdat[LINES-1:0];
        gfip_pkg::OFF_DRIVE_ENABLE_CLEAR: drive_d = drive_q & ~wdat[LINES-1:0];
        gfip_pkg::OFF_FILTER_ENABLE_SET: begin
          filterStatus_d = filterStatus_q | wdat[LINES-1:0];
        end
        gfip_pkg::OFF_FILTER_ENABLE_CLEAR: begin
          filterStatus_d = filterStatus_q & ~wdat[LINES-1:0];
        end
        gfip_pkg::OFF_OUT_LEVEL_SET: level_d = level_q | wdat[LINES-1:0];
        gfip_pkg::OFF_OUT_LEVEL_CLEAR: level_d = level_q & ~wdat[LINES-1:0];
        // direct write only touches lines whose write mask bit is set
        gfip_pkg::OFF_OUT_LEVEL_STATUS: begin
          level_d = (level_q & ~directMask_q) | (wdat[LINES-1:0] & directMask_q);
        end
        gfip_pkg::OFF_CHANGE_IRQ_ENABLE: irqMask_d = irqMask_q | wdat[LINES-1:0];
        gfip_pkg::OFF_CHANGE_IRQ_DISABLE: irqMask_d = irqMask_q & ~wdat[LINES-1:0];
        gfip_pkg::OFF_OPEN_DRAIN_SET: drain_d = drain_q | wdat[LINES-1:0];
        gfip_pkg::OFF_OPEN_DRAIN_CLEAR: drain_d = drain_q & ~wdat[LINES-1:0];
        gfip_pkg::OFF_PULLUP_OFF: pullOff_d = pullOff_q | wdat[LINES-1:0];
        gfip_pkg::OFF_PULLUP_ON: pullOff_d = pullOff_q & ~wdat[LINES-1:0];
        gfip_pkg::OFF_PERIPH_FIRST_SELECT: second_d = second_q & ~wdat[LINES-1:0];
        gfip_pkg::OFF_PERIPH_SECOND_SELECT: second_d = second_q | wdat[LINES-1:0];
        gfip_pkg::OFF_DIRECT_WRITE_MASK_SET: directMask_d = directMask_q | wdat[LINES-1:0];
        gfip_pkg::OFF_DIRECT_WRITE_MASK_CLEAR: directMask_d = directMask_q & ~wdat[LINES-1:0];
        gfip_pkg::OFF_WRITE_PROTECT_MODE: protectMode_d = wdat[gfip_pkg::PROTECT_ENABLE_BIT];
        default: begin
          // delay words sit on four consecutive aligned offsets
          for (int r = 0; r < gfip_pkg::DELAY_REGS; r++) begin
            if (phaseAddr_q == gfip_pkg::OFF_PAD_DELAY_CODES0 + 8'(4 * r)) begin
              delay_d[r] = wdat;
            end
          end
        end
      endcase
    end
  end

  // all registers; filter, mask and protect start cleared so nothing is armed
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      filterStatus_q <= '0;
      irqMask_q <= '0;
      irqStatus_q <= '0;
      lineCtrl_q <= '1;
      drive_q <= '0;
      level_q <= '0;
      drain_q <= '0;
      pullOff_q <= '0;
      second_q <= '0;
      directMask_q <= '0;
      for (int r = 0; r < gfip_pkg::DELAY_REGS; r++) begin
        delay_q[r] <= gfip_pkg::RESET_ZERO;
      end
      protectMode_q <= 1'b0;
      violation_q <= 1'b0;
      violationSrc_q <= 8'h00;
      lastSample_q <= '0;
    end else begin
      filterStatus_q <= filterStatus_d;
      irqMask_q <= irqMask_d;
      irqStatus_q <= irqStatus_d;
      lineCtrl_q <= lineCtrl_d;
      drive_q <= drive_d;
      level_q <= level_d;
      drain_q <= drain_d;
      pullOff_q <= pullOff_d;
      second_q <= second_d;
      directMask_q <= directMask_d;
      delay_q <= delay_d;
      protectMode_q <= protectMode_d;
      violation_q <= violation_d;
      violationSrc_q <= violationSrc_d;
      lastSample_q <= filtered;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // one wired-or request from every pending line whose mask bit is set
  assign changeIrq = |(irqStatus_q & irqMask_q);
  assign lineCtrl = lineCtrl_q;
  assign driveEnable = drive_q;
  assign outLevel = level_q;
  assign openDrain = drain_q;
  assign pullupOff = pullOff_q;
  assign periphSecond = second_q;

  // pads without delay hardware always see code zero
  genvar g;
  generate
    for (g = 0; g < LINES; g++) begin : gDelay
      assign padDelayCodes[4*g +: 4] = DELAY_PADS[g] ? delay_q[g/8][4*(g%8) +: 4] : 4'h0;
    end
  endgenerate

  // ****************************************
  // read data, registered for the data phase
  // ****************************************
  logic [31:0] rdata_q, rdata_d;

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (haddr[7:0])
      gfip_pkg::OFF_LINE_CTRL_STATUS: rdata_d[LINES-1:0] = lineCtrl_q;
      gfip_pkg::OFF_DRIVE_ENABLE_STATUS: rdata_d[LINES-1:0] = drive_q;
      gfip_pkg::OFF_FILTER_STATUS: rdata_d[LINES-1:0] = filterStatus_q;
      gfip_pkg::OFF_OUT_LEVEL_STATUS: rdata_d[LINES-1:0] = level_q;
      gfip_pkg::OFF_PIN_LEVEL_READBACK: rdata_d[LINES-1:0] = filtered;
      gfip_pkg::OFF_CHANGE_IRQ_MASK: rdata_d[LINES-1:0] = irqMask_q;
      gfip_pkg::OFF_CHANGE_IRQ_STATUS: rdata_d[LINES-1:0] = irqStatus_q;
      gfip_pkg::OFF_OPEN_DRAIN_STATUS: rdata_d[LINES-1:0] = drain_q;
      gfip_pkg::OFF_PULLUP_STATUS: rdata_d[LINES-1:0] = pullOff_q;
      gfip_pkg::OFF_PERIPH_SELECT_STATUS: rdata_d[LINES-1:0] = second_q;
      gfip_pkg::OFF_DIRECT_WRITE_MASK_STATUS: rdata_d[LINES-1:0] = directMask_q;
      gfip_pkg::OFF_WRITE_PROTECT_MODE: rdata_d[gfip_pkg::PROTECT_ENABLE_BIT] = protectMode_q;
      gfip_pkg::OFF_WRITE_PROTECT_STATUS: begin
        rdata_d[gfip_pkg::VIOLATION_FLAG_BIT] = violation_q;
        rdata_d[gfip_pkg::VIOLATION_SOURCE_LSB +: 8] = violationSrc_q;
      end
      default: begin
        for (int r = 0; r < gfip_pkg::DELAY_REGS; r++) begin
          if (haddr[7:0] == gfip_pkg::OFF_PAD_DELAY_CODES0 + 8'(4 * r)) begin
            rdata_d = delay_q[r];
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign hrdata = rdata_q;
endmodule
`default_nettype wire

// ### sim/gfip_pin_model.sv
// pin model: pad levels plus short glitches on request
`timescale 1ns/1ps
`default_nettype none
module gfip_pin_model (
  input wire logic clk,
  input wire logic [31:0] level,
  input wire logic [31:0] glitch,
  input wire logic fire,
  output logic [31:0] pinIn
);
  logic glitchOn = 1'b0; // high while a glitch is on the pads
  assign pinIn = glitchOn ? level ^ glitch : level;
  // 1 ns pulse astride a rising edge, so a plain sampler could catch it
  always @(posedge clk) begin
    if (fire) begin
      #4.5 glitchOn = 1'b1;
      #1 glitchOn = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### sim/gfip_asserts.sv
// checker: bus answer, pin path, protection and delay-code properties
`timescale 1ns/1ps
`default_nettype none
module gfip_asserts #(
  parameter int unsigned LINES = 32,
  parameter logic [31:0] DELAY_PADS = 32'h0000_0000
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [LINES-1:0] pinIn,
  input wire logic [LINES-1:0] periphIn,
  input wire logic changeIrq,
  input wire logic [LINES-1:0] lineCtrl,
  input wire logic [LINES-1:0] driveEnable,
  input wire logic [4*LINES-1:0] padDelayCodes
);
  // ****
  // data-phase mirror
  // ****
  logic wrQ, rdQ, protQ; // data phase kinds, protect mode copy
  logic [7:0] addrQ; // offset of the current data phase
  logic [31:0] maskQ; // irq mask copy; the mask is never write protected
  logic [3:0] upQ; // cycles since reset, saturating
  logic [4*LINES-1:0] nibMask; // nibbles of pads that take a delay
  // mirrors bus writes at the same edge the design applies them
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wrQ <= 1'b0;
      rdQ <= 1'b0;
      protQ <= 1'b0;
      addrQ <= 8'h00;
      maskQ <= 32'h0000_0000;
      upQ <= 4'h0;
    end else begin
      wrQ <= hsel && hready && htrans[1] && hwrite;
      rdQ <= hsel && hready && htrans[1] && !hwrite;
      addrQ <= haddr[7:0];
      if (upQ != 4'hF) upQ <= upQ + 4'h1;
      if (wrQ && addrQ == gfip_pkg::OFF_WRITE_PROTECT_MODE) protQ <= hwdata[0];
      if (wrQ && addrQ == gfip_pkg::OFF_CHANGE_IRQ_ENABLE) maskQ <= maskQ | hwdata;
      if (wrQ && addrQ == gfip_pkg::OFF_CHANGE_IRQ_DISABLE) maskQ <= maskQ & ~hwdata;
    end
  end
  for (genvar g = 0; g < LINES; g++) begin
    assign nibMask[4*g +: 4] = {4{DELAY_PADS[g]}};
  end
  // ****
  // properties
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence wpsRead;
    rdQ && addrQ == gfip_pkg::OFF_WRITE_PROTECT_STATUS;
  endsequence
  sequence driveWrite;
    wrQ && addrQ == gfip_pkg::OFF_DRIVE_ENABLE_SET;
  endsequence
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  chk_ready_high: assert property (hreadyout == 1'b1)
    else $error("slave inserted a wait");
  chk_periph_raw: assert property ((upQ == 4'hF && $stable(pinIn)) [*6] |-> periphIn == pinIn)
    else $error("peripheral input is not the settled pin level");
  chk_drive_set: assert property (driveWrite ##0 !protQ |=>
    driveEnable == ($past(driveEnable) | $past(hwdata)))
    else $error("open write did not set drive enables");
  chk_drive_blocked: assert property (driveWrite ##0 protQ |=> $stable(driveEnable))
    else $error("protected write changed drive enables");
  chk_irq_masked: assert property (changeIrq |-> maskQ != 32'h0000_0000)
    else $error("irq raised with every line masked");
  chk_delay_pads: assert property ((padDelayCodes & ~nibMask) == '0)
    else $error("delay code on a pad without delay");
  chk_reset_state: assert property ($fell(reset) |->
    lineCtrl == '1 && driveEnable == '0 && padDelayCodes == '0)
    else $error("state after reset wrong");
  chk_flag_clear: assert property (!wrQ ##1 wpsRead ##1 !wrQ ##1 wpsRead |-> !hrdata[0])
    else $error("violation flag survived a status read");
endmodule
`default_nettype wire

// ### sim/tb_top.sv
// testbench: bus driver, register model and pin stimulus
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ****
  // stimulus and model state
  // ****
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic fire = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] level = 32'h0000_0000;
  logic [31:0] glitch = 32'h0000_0000;
  wire logic hreadyout, hresp, changeIrq;
  wire logic [31:0] hrdata, pinIn, periphIn, driveEnable;
  wire logic [31:0] lineCtrl, outLevel, openDrain, pullupOff, periphSecond;
  wire logic [127:0] padDelayCodes;
  int bad_count = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h0000_005C; // xorshift state
  logic [31:0] mdl [16]; // status words, indexed by offset bits 7:4
  logic [7:0] setOff [9] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h60, 8'h74, 8'hA0};
  logic [127:0] dly;
  logic [31:0] q, a, b;
  logic [7:0] o;
  always #2.5 clk = ~clk;
  gfip_pin_model i_gfip_pin_model (.clk(clk), .level(level), .glitch(glitch), .fire(fire),
    .pinIn(pinIn));
  gfip_gpio_filter_irq_protect #(.LINES(32), .DELAY_PADS(gfip_pkg::DELAY_PADS_PORT_A))
    i_gfip_gpio_filter_irq_protect (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pinIn(pinIn), .periphIn(periphIn),
    .changeIrq(changeIrq), .lineCtrl(lineCtrl), .driveEnable(driveEnable), .outLevel(outLevel),
    .openDrain(openDrain), .pullupOff(pullupOff), .periphSecond(periphSecond),
    .padDelayCodes(padDelayCodes));
  // ****
  // helpers
  // ****
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one single transfer; hready is waited for, never assumed
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d,
    output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, ad};
    htrans <= gfip_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  // every set/clear status word against the model
  task automatic check_status();
    foreach (setOff[i]) begin
      bus(1'b0, {setOff[i][7:4], 4'h8}, 32'h0, q);
      chk("status", q, mdl[setOff[i][7:4]]);
    end
  endtask
  task automatic report_and_stop();
    if (bad_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      bad_count++;
      report_and_stop();
    end
  end
  // ****
  // main sequence
  // ****
  initial begin
    foreach (mdl[i]) mdl[i] = 32'h0000_0000;
    mdl[0] = gfip_pkg::RESET_LINE_CTRL;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    check_status();
    bus(1'b0, 8'h0C, 32'h0, q);
    chk("unmapped", q, 32'h0000_0000);
    bus(1'b0, gfip_pkg::OFF_WRITE_PROTECT_MODE, 32'h0, q);
    chk("protect mode", q, 32'h0000_0000);
    bus(1'b0, gfip_pkg::OFF_PAD_DELAY_CODES0, 32'h0, q);
    chk("delay reset", q, 32'h0000_0000);
    // set then clear on every pair, random bits
    foreach (setOff[i]) begin
      a = rnd();
      b = rnd();
      bus(1'b1, setOff[i], a, q);
      bus(1'b1, setOff[i] ^ 8'h04, b, q);
      mdl[setOff[i][7:4]] = (mdl[setOff[i][7:4]] | a) & ~b;
    end
    check_status();
    chk("drive port", driveEnable, mdl[1]);
    chk("line port", lineCtrl, mdl[0]);
    chk("level port", outLevel, mdl[3]);
    chk("drain port", openDrain, mdl[5]);
    chk("pull port", pullupOff, mdl[6]);
    chk("second port", periphSecond, mdl[7]);
    // delay codes: only listed pads keep theirs
    for (int w = 0; w < 4; w++) begin
      dly[32*w +: 32] = rnd();
      bus(1'b1, 8'hC0 + 8'(4*w), dly[32*w +: 32], q);
    end
    @(posedge clk);
    for (int g = 0; g < 32; g++) if (!gfip_pkg::DELAY_PADS_PORT_A[g]) dly[4*g +: 4] = 4'h0;
    for (int w = 0; w < 4; w++) chk("delay", padDelayCodes[32*w +: 32], dly[32*w +: 32]);
    // protection: all sixteen writes blocked and reported
    bus(1'b1, gfip_pkg::OFF_WRITE_PROTECT_MODE, 32'h0000_0001, q);
    foreach (setOff[i]) if (setOff[i] != 8'h40) for (int k = 0; k < 2; k++) begin
      o = setOff[i] ^ (k == 1 ? 8'h04 : 8'h00);
      bus(1'b1, o, rnd(), q);
      bus(1'b0, gfip_pkg::OFF_WRITE_PROTECT_STATUS, 32'h0, q);
      chk("violation", q & 32'h0000_FF01, {16'h0000, o, 8'h01});
    end
    bus(1'b0, gfip_pkg::OFF_WRITE_PROTECT_STATUS, 32'h0, q);
    chk("flag cleared", q & 32'h0000_0001, 32'h0000_0000);
    check_status();
    bus(1'b1, gfip_pkg::OFF_WRITE_PROTECT_MODE, 32'h0, q);
    // change detection, mask and read-clear
    bus(1'b1, 8'h44, 32'hFFFF_FFFF, q);
    bus(1'b1, 8'h24, 32'hFFFF_FFFF, q);
    bus(1'b0, 8'h4C, 32'h0, q);
    a = rnd() | 32'h0000_0100;
    level <= a;
    repeat (12) @(posedge clk);
    chk("irq masked", {31'h0, changeIrq}, 32'h0);
    bus(1'b1, 8'h40, 32'h0000_0100, q);
    @(posedge clk);
    chk("irq", {31'h0, changeIrq}, 32'h1);
    bus(1'b0, 8'h3C, 32'h0, q);
    chk("readback", q, a);
    chk("periph", periphIn, a);
    bus(1'b0, 8'h4C, 32'h0, q);
    chk("changes", q, a);
    bus(1'b0, 8'h4C, 32'h0, q);
    chk("cleared", q, 32'h0);
    chk("irq low", {31'h0, changeIrq}, 32'h0);
    // filter: glitch rejected, two-cycle pulse kept
    b = rnd();
    bus(1'b1, 8'h20, b, q);
    glitch <= 32'hFFFF_FFFF;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (12) @(posedge clk);
    bus(1'b0, 8'h4C, 32'h0, q);
    chk("glitch", q & b, 32'h0);
    level <= a ^ b;
    repeat (2) @(posedge clk);
    level <= a;
    repeat (12) @(posedge clk);
    bus(1'b0, 8'h4C, 32'h0, q);
    chk("pulse", q, b);
    report_and_stop();
  end
endmodule
bind gfip_gpio_filter_irq_protect gfip_asserts #(.LINES(LINES), .DELAY_PADS(DELAY_PADS))
  i_gfip_asserts (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .pinIn(pinIn), .periphIn(periphIn), .changeIrq(changeIrq),
  .lineCtrl(lineCtrl), .driveEnable(driveEnable), .padDelayCodes(padDelayCodes));
`default_nettype wire
